/* rtl/asd_pkg.sv */
// Notes on behaviour
// R1: Addressed call, CB 0, I4 0, nonzero address: drive I3..I0 out, reply inputs.
// R2: Addressed call, CB 0, I4 1, nonzero address: drive parameter bits, reply parameter.
// R3: At address zero, CB 0 to address zero stores I4..I0 as address, reply 6.
// R4: At address zero, CB 1, address zero, I4 0 stores extended ID 1, reply 0.
// R5: Addressed CB 1, I4 0, I2..I0 zero clears the slave address, reply 0.
// R6: Addressed CB 1, I4 I2 I1 I0 = 1100 resets the slave, reply 6.
// R7: Addressed CB 1, I4 1, I2 0 reads IO config, ID, ext ID 1 or 2.
// R8: Addressed CB 1, I4 I2 I1 I0 = 1110 replies with status bits.
// R9: CB 1, address 11111, info 10101 is broadcast reset, never answered.
// R10: At address zero, CB 1, address zero, info 11101 enters program mode silently.
// R11: Program mode entry is ignored while program mode disable is set.
// R12: Extended addressing: I3 carries select bit, direct or inverted per call type.
// R13: Data and parameter calls only at nonzero address outside program mode.
// R14: No data or parameter call for about 41 ms raises status LED A, or pulses chip_reset instead when the watchdog is enabled.
// R15: With watchdog enabled, timer expiry triggers a complete chip reset.
// R16: When configured, parameter pin 0 level enables the watchdog.
// R17: Safety mode bypasses input filtering so inputs reach the reply after the two synchronizer stages only.
// R18: Status LED B stays disabled after reset until configured on.
// R19: Extended ID 1 can be write protected by a configuration bit.
// R20: With protection set, reading extended ID 1 returns the protected value.
// R21: Protection in extended addressing blocks bits 2..0 only, bit 3 stays writable.
// R22: A configuration bit keeps the watchdog on regardless of parameter pin 0.
// R23: Telegrams with bad parity or end bit are dropped without answer or effect.
package asd_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CODES = 8'h04;
   localparam logic [7:0] OFS_STATE = 8'h08;

   // Control register bits
   localparam int CTRL_EXT_ADDR   = 0;
   localparam int CTRL_PROG_DIS   = 1;
   localparam int CTRL_WD_PIN     = 2;
   localparam int CTRL_WD_ACTIVE  = 3;
   localparam int CTRL_SAFETY     = 4;
   localparam int CTRL_LED_B_EN   = 5;
   localparam int CTRL_ID1_LOCK   = 6;
   localparam int CTRL_FILTER_EN  = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Codes register fields (low bit of each nibble)
   localparam int CODES_IO      = 0;
   localparam int CODES_ID      = 4;
   localparam int CODES_ID2     = 8;
   localparam int CODES_PROT_ID1 = 12;
   localparam int CODES_INVERT  = 16;
   localparam int CODES_STATUS  = 20;
   localparam logic [23:0] CODES_RESET = 24'h000000;

   // State register fields
   localparam int STATE_ADDR    = 0;
   localparam int STATE_ID1     = 8;
   localparam int STATE_PROG    = 12;
   localparam int STATE_NOEXCH  = 13;

   // ************************************************************
   // Telegram constants
   // ************************************************************
   localparam logic [3:0] RESP_ACK      = 4'h6;
   localparam logic [3:0] RESP_ZERO     = 4'h0;
   localparam logic [4:0] ADDR_ZERO     = 5'h00;
   localparam logic [4:0] BCAST_ADDR    = 5'h1f;
   localparam logic [4:0] BCAST_INFO    = 5'h15;
   localparam logic [4:0] PROGRAM_ENTRY_CALL_INFO     = 5'h1d;
   localparam logic [2:0] LOW_RESET     = 3'h4;
   localparam logic [2:0] LOW_STATUS    = 3'h6;
   localparam logic [3:0] PARAM_RESET   = 4'hf;
   localparam logic [3:0] DATA_RESET    = 4'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS   = 8;
   localparam int TICK_NS         = 1000000;
   localparam int TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
   localparam int COMM_TIMEOUT_MS = 41;
   localparam int TICK_W          = 24;
   localparam int TO_W            = 8;
   localparam int FILT_CYC        = 8;
   localparam int FILT_W          = 4;

   typedef enum logic {
      MODE_SLAVE   = 1'b0,
      MODE_PROGRAM = 1'b1
   } asd_mode_t;

   typedef struct packed {
      logic       st;
      logic       cb;
      logic [4:0] addr;
      logic [4:0] info;
      logic       pb;
      logic       eb;
   } asd_req_t;

   typedef struct packed {
      logic [3:0] data;
      logic       pb;
   } asd_resp_t;

   typedef struct packed {
      logic [3:0]        din_s1;
      logic [3:0]        din_s2;
      logic              p0_s1;
      logic              p0_s2;
      logic [3:0]        din_filt;
      logic [FILT_W-1:0] filt_cnt;
      logic [4:0]        slave_addr;
      logic [3:0]        ext_id1;
      asd_mode_t         mode;
      logic              no_exch;
      logic [TICK_W-1:0] tick_cnt;
      logic [TO_W-1:0]   to_cnt;
      logic [7:0]        ctrl;
      logic [23:0]       codes;
      logic [3:0]        data_out;
      logic              data_strobe;
      logic [3:0]        param_out;
      logic              param_strobe;
      logic              resp_valid;
      asd_resp_t         resp;
      logic              slave_reset;
      logic              chip_reset;
      logic              led_b;
      logic              pready;
      logic [31:0]       prdata;
      logic              pslverr;
   } asd_state_t;

endpackage : asd_pkg

/* rtl/asd_call_decoder.sv */
`timescale 1ns/1ps
module asd_call_decoder
   import asd_pkg::*;
#(
   parameter int TICK_CYCLES   = asd_pkg::TICK_CYC,
   parameter int TIMEOUT_TICKS = asd_pkg::COMM_TIMEOUT_MS
) (
   input  wire logic        pclk,          // System clock, 125 MHz
   input  wire logic        presetn,       // Asynchronous reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error on unmapped address
   input  wire logic        req_valid,     // One-cycle strobe, request received
   input  wire asd_req_t    req,           // Received request telegram
   output logic             resp_valid,    // One-cycle strobe, response to send
   output asd_resp_t        resp,          // Response nibble and parity
   input  wire logic [3:0]  din,           // Data input pins
   input  wire logic        param_pin0,    // Parameter pin 0 level
   output logic      [3:0]  data_out,      // Data output port
   output logic             data_strobe,   // Pulse on data exchange
   output logic      [3:0]  param_out,     // Parameter output port
   output logic             param_strobe,  // Pulse on parameter write
   output logic             status_led_a,  // No data or parameter exchange
   output logic             status_led_b,  // Communication good, when enabled
   output logic             program_mode,  // Program mode active
   output logic             slave_reset,   // Pulse on slave or broadcast reset
   output logic             chip_reset     // Pulse on watchdog expiry
);

   asd_state_t r;
   asd_state_t n;

   // ************************************************************
   // Request decode
   // ************************************************************
   logic       tel_ok;
   logic       ext;
   logic       sel;
   logic       addr_hit;
   logic       at_zero;
   logic       in_prog;
   logic       sel_ok;
   logic       nsel_ok;
   logic       data_exchange_call;
   logic       parameter_write_call;
   logic       address_assign_call;
   logic       ext_id1_write_call;
   logic       address_delete_call;
   logic       bcast;
   logic       program_entry_call;
   logic       rst_call;
   logic       rd_call;
   logic       status_read_call;
   logic       wd_en;
   logic       tick;
   logic [3:0] din_eff;
   logic [3:0] id1_view;
   logic [3:0] rd_val;
   logic       setup;
   logic       wr_acc;
   logic       mapped;
   logic [31:0] rd_mux;

   assign tel_ok  = req_valid & ~req.st & req.eb
                    & ~(^{req.cb, req.addr, req.info, req.pb});  // see R23
   assign ext     = r.ctrl[CTRL_EXT_ADDR];
   assign sel     = ext & r.ext_id1[3];                          // see R12
   assign addr_hit = (req.addr == r.slave_addr);
   assign at_zero = (r.slave_addr == ADDR_ZERO);
   assign in_prog = (r.mode == MODE_PROGRAM);
   assign sel_ok  = (req.info[3] == sel);                        // see R12
   assign nsel_ok = (req.info[3] == ~sel);                       // see R12

   // Data and parameter calls need a live address outside program mode
   assign data_exchange_call = tel_ok & ~req.cb & addr_hit & ~at_zero & ~in_prog
                 & ~req.info[4] & (~ext | nsel_ok);              // see R1, R13
   assign parameter_write_call = tel_ok & ~req.cb & addr_hit & ~at_zero & ~in_prog
                 & req.info[4] & (~ext | nsel_ok);               // see R2, R13
   assign address_assign_call = tel_ok & ~req.cb & at_zero & ~in_prog
                 & (req.addr == ADDR_ZERO);                      // see R3
   assign ext_id1_write_call = tel_ok & req.cb & at_zero & ~in_prog
                 & (req.addr == ADDR_ZERO) & ~req.info[4];       // see R4
   assign address_delete_call = tel_ok & req.cb & addr_hit & ~at_zero & ~req.info[4]
                 & (req.info[2:0] == 3'h0) & sel_ok;             // see R5
   assign bcast = tel_ok & req.cb & (req.addr == BCAST_ADDR)
                  & (req.info == BCAST_INFO);                    // see R9
   assign program_entry_call = tel_ok & req.cb & at_zero & (req.addr == ADDR_ZERO)
                 & (req.info == PROGRAM_ENTRY_CALL_INFO)
                 & ~r.ctrl[CTRL_PROG_DIS];                       // see R10, R11
   assign rst_call = tel_ok & req.cb & addr_hit & req.info[4]
                     & (req.info[2:0] == LOW_RESET) & nsel_ok;   // see R6
   assign rd_call = tel_ok & req.cb & addr_hit & req.info[4]
                    & ~req.info[2] & sel_ok;                     // see R7
   assign status_read_call = tel_ok & req.cb & addr_hit & req.info[4]
                 & (req.info[2:0] == LOW_STATUS) & nsel_ok;      // see R8

   // Safety mode skips the debounce stage entirely
   assign din_eff = (r.ctrl[CTRL_SAFETY] | ~r.ctrl[CTRL_FILTER_EN])
                    ? (r.din_s2 ^ r.codes[CODES_INVERT +: 4])
                    : (r.din_filt ^ r.codes[CODES_INVERT +: 4]);  // see R17

   // Protected value stands in for reads; bit 3 stays the live select in ext mode
   assign id1_view = ~r.ctrl[CTRL_ID1_LOCK] ? r.ext_id1
                     : ext ? {r.ext_id1[3], r.codes[CODES_PROT_ID1 +: 3]}
                     : r.codes[CODES_PROT_ID1 +: 4];             // see R20

   always_comb begin
      unique case (req.info[1:0])
         2'b00:   rd_val = r.codes[CODES_IO +: 4];
         2'b01:   rd_val = r.codes[CODES_ID +: 4];
         2'b10:   rd_val = id1_view;
         2'b11:   rd_val = r.codes[CODES_ID2 +: 4];
      endcase
   end

   assign wd_en = r.ctrl[CTRL_WD_ACTIVE]
                  | (r.ctrl[CTRL_WD_PIN] & r.p0_s2);             // see R16, R22
   assign tick  = (r.tick_cnt == TICK_W'(TICK_CYCLES - 1));

   // ************************************************************
   // APB slave
   // ************************************************************
   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & r.pready & pwrite & ~r.pslverr;
   assign mapped = (paddr == OFS_CTRL) | (paddr == OFS_CODES) | (paddr == OFS_STATE);

   always_comb begin
      rd_mux = 32'h00000000;
      if (paddr == OFS_CTRL) begin
         rd_mux[7:0] = r.ctrl;
      end else if (paddr == OFS_CODES) begin
         rd_mux[23:0] = r.codes;
      end else if (paddr == OFS_STATE) begin
         rd_mux[STATE_ADDR +: 5] = r.slave_addr;
         rd_mux[STATE_ID1 +: 4]  = r.ext_id1;
         rd_mux[STATE_PROG]      = in_prog;
         rd_mux[STATE_NOEXCH]    = r.no_exch;
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      n = r;
      n.data_strobe  = 1'b0;
      n.param_strobe = 1'b0;
      n.resp_valid   = 1'b0;
      n.slave_reset  = 1'b0;
      n.chip_reset   = 1'b0;

      n.din_s1 = din;
      n.din_s2 = r.din_s1;
      n.p0_s1  = param_pin0;
      n.p0_s2  = r.p0_s1;

      // Debounce: a new level must hold FILT_CYC cycles before it is taken
      if (r.din_s2 == r.din_filt) begin
         n.filt_cnt = '0;
      end else if (r.filt_cnt == FILT_W'(FILT_CYC - 1)) begin
         n.din_filt = r.din_s2;
         n.filt_cnt = '0;
      end else begin
         n.filt_cnt = r.filt_cnt + FILT_W'(1);
      end

      n.pready  = setup;
      n.pslverr = setup & ~mapped;
      n.prdata  = (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (wr_acc) begin
         if (paddr == OFS_CTRL) begin
            n.ctrl = pwdata[7:0];
         end else if (paddr == OFS_CODES) begin
            n.codes = pwdata[23:0];
         end else begin
            n.slave_addr = pwdata[STATE_ADDR +: 5];
            n.ext_id1    = pwdata[STATE_ID1 +: 4];
         end
      end

      // Communication monitor on a 1 ms enable
      n.tick_cnt = tick ? '0 : r.tick_cnt + TICK_W'(1);
      if (data_exchange_call | parameter_write_call) begin
         n.to_cnt  = '0;
         n.no_exch = 1'b0;                                       // see R14
      end else if (tick & ~r.no_exch) begin
         if (r.to_cnt == TO_W'(TIMEOUT_TICKS - 1)) begin
            n.to_cnt  = '0;
            n.no_exch = 1'b1;                                    // see R14
            if (wd_en) begin
               n.chip_reset = 1'b1;                              // see R15
               n.no_exch    = 1'b0;
               n.data_out   = DATA_RESET;
               n.param_out  = PARAM_RESET;
               n.mode       = MODE_SLAVE;
            end
         end else begin
            n.to_cnt = r.to_cnt + TO_W'(1);
         end
      end

      // Calls override a same-cycle register write
      if (data_exchange_call) begin
         n.data_out    = ext ? {r.data_out[3], req.info[2:0]} : req.info[3:0]; // see R1, R12
         n.data_strobe = 1'b1;
         n.resp_valid  = 1'b1;
         n.resp.data   = din_eff;                                // see R1
      end
      if (parameter_write_call) begin
         n.param_out    = ext ? {r.param_out[3], req.info[2:0]} : req.info[3:0]; // see R2
         n.param_strobe = 1'b1;
         n.resp_valid   = 1'b1;
         n.resp.data    = ext ? {r.param_out[3], req.info[2:0]} : req.info[3:0];
      end
      if (address_assign_call) begin
         n.slave_addr = req.info;                                // see R3
         n.resp_valid = 1'b1;
         n.resp.data  = RESP_ACK;
      end
      if (ext_id1_write_call) begin
         if (~r.ctrl[CTRL_ID1_LOCK]) begin
            n.ext_id1 = req.info[3:0];                           // see R19
         end else if (ext) begin
            n.ext_id1 = {req.info[3], r.ext_id1[2:0]};           // see R21
         end
         n.resp_valid = 1'b1;
         n.resp.data  = RESP_ZERO;                               // see R4
      end
      if (address_delete_call) begin
         n.slave_addr = ADDR_ZERO;                               // see R5
         n.resp_valid = 1'b1;
         n.resp.data  = RESP_ZERO;
      end
      if (rst_call | bcast) begin
         n.data_out    = DATA_RESET;                             // see R6, R9
         n.param_out   = PARAM_RESET;
         n.mode        = MODE_SLAVE;
         n.slave_reset = 1'b1;
         n.resp_valid  = rst_call;                               // see R9
         n.resp.data   = RESP_ACK;
      end
      if (rd_call) begin
         n.resp_valid = 1'b1;
         n.resp.data  = rd_val;                                  // see R7
      end
      if (status_read_call) begin
         n.resp_valid = 1'b1;
         n.resp.data  = r.codes[CODES_STATUS +: 4];              // see R8
      end
      unique case (r.mode)
         MODE_SLAVE: begin
            if (program_entry_call) begin
               n.mode = MODE_PROGRAM;                            // see R10
            end
         end
         MODE_PROGRAM: begin
         end
      endcase
      n.resp.pb = ^n.resp.data;
      n.led_b   = n.ctrl[CTRL_LED_B_EN] & ~n.no_exch;           // see R18
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r            <= '0;
         r.mode       <= MODE_SLAVE;
         r.ctrl       <= CTRL_RESET;                             // see R18
         r.codes      <= CODES_RESET;
         r.data_out   <= DATA_RESET;
         r.param_out  <= PARAM_RESET;
      end else begin
         r <= n;
      end
   end

   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
   assign resp_valid   = r.resp_valid;
   assign resp         = r.resp;
   assign data_out     = r.data_out;
   assign data_strobe  = r.data_strobe;
   assign param_out    = r.param_out;
   assign param_strobe = r.param_strobe;
   assign status_led_a = r.no_exch;                              // see R14
   assign status_led_b = r.led_b;
   assign program_mode = (r.mode == MODE_PROGRAM);
   assign slave_reset  = r.slave_reset;
   assign chip_reset   = r.chip_reset;

endmodule : asd_call_decoder

/* sim/asd_call_decoder_checker.sv */
`timescale 1ns/1ps
module asd_call_decoder_checker
   import asd_pkg::*;
(
   input  wire logic      pclk,          // Clock
   input  wire logic      presetn,       // Reset, active low
   input  wire logic      req_valid,     // Request strobe
   input  wire asd_req_t  req,           // Request telegram
   input  wire logic      resp_valid,    // Answer strobe
   input  wire asd_resp_t resp,          // Answer nibble
   input  wire logic [3:0] data_out,     // Data port
   input  wire logic      data_strobe,   // Data strobe
   input  wire logic [3:0] param_out,    // Parameter port
   input  wire logic      param_strobe,  // Parameter strobe
   input  wire logic      status_led_a,  // No exchange
   input  wire logic      status_led_b,  // Exchange good
   input  wire logic      slave_reset    // Reset pulse
);
   // **********
   // Frame decode seen from the wire
   // **********
   default clocking dclk @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire ok_f  = !req.st && req.eb && !(^{req.cb, req.addr, req.info, req.pb});
   wire bcast = req_valid && ok_f && req.cb && req.addr == BCAST_ADDR && req.info == BCAST_INFO;
   wire prog  = req_valid && ok_f && req.cb && req.addr == ADDR_ZERO && req.info == PROGRAM_ENTRY_CALL_INFO;
   wire rst_c = req_valid && ok_f && req.cb && req.info[4] && req.info[2:0] == LOW_RESET;

   bcast_silent_a: assert property (bcast |=> !resp_valid && slave_reset)
      else $error("broadcast misbehaved");
   prog_silent_a: assert property (prog |=> !resp_valid)
      else $error("program entry answered");
   bad_frame_a: assert property (req_valid && !ok_f |=>
      !resp_valid && !data_strobe && !param_strobe && !slave_reset)
      else $error("broken frame acted");
   data_cause_a: assert property (data_strobe |-> resp_valid &&
      $past(req_valid && !req.cb && !req.info[4]) && data_out[2:0] == $past(req.info[2:0]))
      else $error("stray data strobe");
   param_cause_a: assert property (param_strobe |-> resp_valid &&
      $past(req_valid && !req.cb && req.info[4]) && resp.data[2:0] == param_out[2:0])
      else $error("stray parameter strobe");
   resp_par_a: assert property (resp_valid |-> resp.pb == ^resp.data)
      else $error("answer parity wrong");
   resp_cause_a: assert property (resp_valid |-> $past(req_valid && ok_f))
      else $error("stray answer");
   srst_cause_a: assert property (slave_reset |-> $past(rst_c || bcast))
      else $error("stray slave reset");
   led_excl_a: assert property (status_led_b |-> !status_led_a)
      else $error("both status lights on");
   exch_clears_a: assert property (data_strobe || param_strobe |=> !status_led_a)
      else $error("exchange did not clear monitor");
endmodule : asd_call_decoder_checker

bind asd_call_decoder asd_call_decoder_checker u_checker (
   .pclk, .presetn, .req_valid, .req, .resp_valid, .resp, .data_out, .data_strobe,
   .param_out, .param_strobe, .status_led_a, .status_led_b, .slave_reset);

/* sim/asd_master_model.sv */
`timescale 1ns/1ps
module asd_master_model
   import asd_pkg::*;
(
   input  wire logic      pclk,        // Clock
   output logic           req_valid,   // Request strobe
   output asd_req_t       req,         // Request telegram
   input  wire logic      resp_valid,  // Answer strobe
   input  wire asd_resp_t resp         // Answer nibble
);
   // **********
   // Telegram sender
   // **********
   initial {req_valid, req} = '0;

   // Even parity; a broken frame drops its end bit
   task automatic send(input logic cb, input logic [4:0] a, i, input logic bad,
                       output logic v, output logic [3:0] d);
      @(posedge pclk);
      req_valid <= 1'b1;
      req       <= '{st: 1'b0, cb: cb, addr: a, info: i, pb: ^{cb, a, i}, eb: ~bad};
      @(posedge pclk);
      req_valid <= 1'b0;
      req       <= ~req; // Idle lines show the inverse
      #1;
      v = resp_valid;
      d = resp.data;
   endtask : send
endmodule : asd_master_model

/* sim/asd_call_decoder_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module asd_call_decoder_tb;
   import asd_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, param_pin0 = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_s;
   logic [3:0]  din = 4'h0, data_out, param_out;
   logic        pready, pslverr, req_valid, resp_valid, data_strobe, param_strobe, er_s;
   logic        status_led_a, status_led_b, program_mode, slave_reset, chip_reset;
   asd_req_t    req;
   asd_resp_t   resp;
   int          n_mismatch = 0, tests_run = 0, cyc = 0, n_chip = 0, n_srst = 0;

   always #4 pclk = ~pclk;

   asd_call_decoder #(.TICK_CYCLES(10), .TIMEOUT_TICKS(3)) u_asd_call_decoder (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .req_valid, .req, .resp_valid, .resp, .din, .param_pin0, .data_out,
      .data_strobe, .param_out, .param_strobe, .status_led_a, .status_led_b,
      .program_mode, .slave_reset, .chip_reset);
   asd_master_model u_asd_master_model (.pclk, .req_valid, .req, .resp_valid, .resp);

   // **********
   // Bus and telegram helpers
   // **********
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   always @(posedge pclk) begin
      cyc++;
      if (chip_reset === 1'b1) n_chip++;
      if (slave_reset === 1'b1) n_srst++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd_s, er_s);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, ex, input string nm);
      apb(1'b0, a, 32'h0, rd_s, er_s);
      `CHK(nm, ex, rd_s & m)
   endtask : rchk

   task automatic call(input logic cb, input logic [4:0] a, i, input logic ev,
                       input logic [3:0] ed, input string nm, input logic bad = 1'b0);
      logic       v;
      logic [3:0] d;
      u_asd_master_model.send(cb, a, i, bad, v, d);
      `CHK(nm, ev, v)
      if (ev) `CHK(nm, ed, d)
   endtask : call

   // **********
   // Scenarios
   // **********
   task automatic t_reset();
      `CHK("param_out", PARAM_RESET, param_out)
      `CHK("led_b", 1'b0, status_led_b)
      rchk(OFS_CTRL, 32'hff, 32'h0, "ctrl");
      apb(1'b0, 8'h0c, 32'h0, rd_s, er_s);
      `CHK("unmapped", 1'b1, er_s)
   endtask : t_reset

   task automatic t_id1();
      wr(OFS_CODES, 32'h0090cb73);
      call(1'b1, 5'h00, 5'h05, 1'b1, RESP_ZERO, "id1 write");
      rchk(OFS_STATE, 32'hf00, 32'h500, "id1 stored");
      wr(OFS_CTRL, 32'h40);
      call(1'b1, 5'h00, 5'h0a, 1'b1, RESP_ZERO, "locked write");
      rchk(OFS_STATE, 32'hf00, 32'h500, "id1 kept");
      call(1'b1, 5'h00, 5'h12, 1'b1, 4'hc, "protected read");
      wr(OFS_CTRL, 32'h41);
      call(1'b1, 5'h00, 5'h0a, 1'b1, RESP_ZERO, "ext write");
      rchk(OFS_STATE, 32'hf00, 32'hd00, "select bit only");
      call(1'b1, 5'h00, 5'h1a, 1'b1, 4'hc, "ext protected read");
      call(1'b1, 5'h00, 5'h12, 1'b0, 4'h0, "wrong select");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_STATE, 32'h0);
   endtask : t_id1

   task automatic t_prog();
      int s;
      wr(OFS_CTRL, 32'h2);
      call(1'b1, 5'h00, PROGRAM_ENTRY_CALL_INFO, 1'b0, 4'h0, "prog disabled");
      `CHK("prog off", 1'b0, program_mode)
      wr(OFS_CTRL, 32'h0);
      call(1'b1, 5'h00, PROGRAM_ENTRY_CALL_INFO, 1'b0, 4'h0, "prog entry");
      `CHK("prog on", 1'b1, program_mode)
      s = n_srst;
      call(1'b1, 5'h00, 5'h1c, 1'b1, RESP_ACK, "reset call");
      @(posedge pclk) #1;
      `CHK("prog left", 1'b0, program_mode)
      `CHK("reset pulse", s + 1, n_srst)
   endtask : t_prog

   task automatic t_data();
      call(1'b0, 5'h00, 5'h05, 1'b1, RESP_ACK, "assign");
      rchk(OFS_STATE, 32'h1f, 32'h5, "address");
      wr(OFS_CTRL, 32'hb0);
      @(posedge pclk);
      din <= 4'ha;
      repeat (3) @(posedge pclk);
      call(1'b0, 5'h05, 5'h03, 1'b1, 4'ha, "data reply");
      `CHK("data_out", 4'h3, data_out)
      `CHK("led_b on", 1'b1, status_led_b)
      call(1'b0, 5'h05, 5'h16, 1'b1, 4'h6, "param reply");
      `CHK("param_out", 4'h6, param_out)
      call(1'b0, 5'h05, 5'h0c, 1'b0, 4'h0, "bad frame", 1'b1);
      `CHK("data kept", 4'h3, data_out)
   endtask : t_data

   task automatic t_reads();
      logic [3:0] ex [4] = '{4'h3, 4'h7, 4'h0, 4'hb};
      for (int k = 0; k < 4; k++) begin
         call(1'b1, 5'h05, 5'(5'h10 + k), 1'b1, ex[k], "read");
      end
      call(1'b1, 5'h05, 5'h1e, 1'b1, 4'h9, "status");
   endtask : t_reads

   task automatic t_delete();
      int s;
      call(1'b1, 5'h05, 5'h00, 1'b1, RESP_ZERO, "delete");
      rchk(OFS_STATE, 32'h1f, 32'h0, "address cleared");
      call(1'b0, 5'h05, 5'h03, 1'b0, 4'h0, "stale address");
      s = n_srst;
      call(1'b1, BCAST_ADDR, BCAST_INFO, 1'b0, 4'h0, "broadcast");
      @(posedge pclk) #1;
      `CHK("broadcast pulse", s + 1, n_srst)
   endtask : t_delete

   task automatic t_monitor();
      int c;
      call(1'b0, 5'h00, 5'h05, 1'b1, RESP_ACK, "reassign");
      wr(OFS_CTRL, 32'h20);
      call(1'b0, 5'h05, 5'h01, 1'b1, 4'ha, "keepalive");
      repeat (10) @(posedge pclk);
      `CHK("led_a early", 1'b0, status_led_a)
      repeat (50) @(posedge pclk);
      `CHK("led_a late", 1'b1, status_led_a)
      `CHK("led_b off", 1'b0, status_led_b)
      c = n_chip;
      wr(OFS_CTRL, 32'h8);
      call(1'b0, 5'h05, 5'h01, 1'b1, 4'ha, "kick");
      repeat (50) @(posedge pclk);
      `CHK("watchdog on", 1'b1, n_chip > c)
      wr(OFS_CTRL, 32'h4);
      repeat (2) @(posedge pclk);
      c = n_chip;
      repeat (50) @(posedge pclk);
      `CHK("pin low", 1'b1, n_chip == c)
      param_pin0 <= 1'b1;
      call(1'b0, 5'h05, 5'h01, 1'b1, 4'ha, "kick pin");
      repeat (50) @(posedge pclk);
      `CHK("pin high", 1'b1, n_chip > c)
      wr(OFS_CTRL, 32'h0);
   endtask : t_monitor

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_id1();
      t_prog();
      t_data();
      t_reads();
      t_delete();
      t_monitor();
      complete_run();
   end
endmodule : asd_call_decoder_tb
